// ### hw/stdp_pkg.sv
// Purpose: Shared constants and types for the standby / tamper-detect serial port
// Assumes: 10 MHz system clock, serial clock sampled as an ordinary input
// Notes:   Timing figures kept in their own units, cycle counts derived
package stdp_pkg;

	// ****************************************
	// Serial frame
	// ****************************************
	localparam int          WORD_BITS     = 16;
	localparam logic [15:0] CMD_STANDBY   = 16'h0022;
	localparam logic [15:0] CMD_WAKEUP    = 16'h0033;

	// ****************************************
	// Power levels
	// ****************************************
	typedef enum logic [1:0] {
		PWR_MINIMAL  = 2'h0,
		PWR_REDUCED  = 2'h1,
		PWR_HIGH_RES = 2'h2,
		PWR_HIGH_ALT = 2'h3
	} stdp_power_t;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ              = 10_000_000;
	localparam int MOD_SETTLE_PERIODS  = 8;
	localparam int TAMPER_RATE_SPS     = 2700;
	localparam int TAMPER_SAMPLE_CYC   = CLK_HZ / TAMPER_RATE_SPS;
	localparam int RESET_RECOG_NS      = 2000;
	localparam int CLK_NS              = 100;
	localparam int RESET_RECOG_CYC     = (RESET_RECOG_NS + CLK_NS - 1) / CLK_NS;

	// ****************************************
	// Tamper detection
	// ****************************************
	localparam int THRESH_BITS    = 24;
	localparam int WINDOW_UNIT    = 128;
	localparam int WINDOW_MAX     = 3584;
	localparam int CHANNELS       = 2;

	typedef struct packed {
		logic                   enable;
		logic                   requireEvery;
		logic [2:0]             windowLength;
		logic [2:0]             hitCount;
		logic [THRESH_BITS-1:0] threshold;
	} stdp_tamper_cfg_t;

	typedef struct packed {
		logic [CHANNELS-1:0]    valid;
		logic [THRESH_BITS-1:0] sample0;
		logic [THRESH_BITS-1:0] sample1;
	} stdp_samples_t;

	typedef enum logic [3:0] {
		MODE_RUN     = 4'b0001,
		MODE_STANDBY = 4'b0010,
		MODE_TAMPER  = 4'b0100,
		MODE_SETTLE  = 4'b1000
	} stdp_mode_t;

endpackage : stdp_pkg

// ### hw/stdp_word_buffer.sv
// Purpose: Two-entry valid/ready buffer for transmit words
// Assumes: Single clock domain
// Notes:   Full and empty are exact
`timescale 1ns/1ns
`default_nettype none
module stdp_word_buffer
	import stdp_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wrPtr_q;
	logic [PW-1:0]    rdPtr_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;

	assign inReady  = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem_q[rdPtr_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule : stdp_word_buffer
`default_nettype wire

// ### hw/stdp_tamper_window.sv
// Purpose: One tamper-detection run: counts samples and threshold hits
// Assumes: Sample strobe from the internal oscillator tick
// Notes:   Counters clear on every start
`timescale 1ns/1ns
`default_nettype none
module stdp_tamper_window
	import stdp_pkg::*;
#(
	parameter int CH = CHANNELS
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             start,
	input  wire logic             sampleStrobe,
	input  wire stdp_samples_t    samples,
	input  wire stdp_tamper_cfg_t cfg,
	input  wire logic [CH-1:0]    chanEnable,
	output logic                  detect,
	output logic                  done
);

	logic [11:0]   sampleCnt_q;
	logic [2:0]    hits_q [CH];
	logic [CH-1:0] met;
	logic [CH-1:0] over;
	logic [11:0]   windowLen;
	logic          busy_q;

	// Even steps from the shortest window, top code gives the longest
	localparam logic [2:0] LEN_TOP     = '1;
	localparam int         WINDOW_STEP = (WINDOW_MAX - WINDOW_UNIT) / int'(LEN_TOP);
	assign windowLen = (cfg.windowLength == LEN_TOP) ? 12'(WINDOW_MAX) :
		12'(WINDOW_UNIT) + 12'(WINDOW_STEP) * 12'(cfg.windowLength);

	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gCh
			logic [THRESH_BITS-1:0] s;
			logic [THRESH_BITS-1:0] mag;
			assign s    = (g == 0) ? samples.sample0 : samples.sample1;
			assign mag  = s[THRESH_BITS-1] ? (~s + 1'b1) : s;
			assign over[g] = mag > cfg.threshold;
			assign met[g]  = (hits_q[g] >= cfg.hitCount) && (cfg.hitCount != 3'h0 || 1'b1);
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					hits_q[g] <= '0;
				end else if (start) begin
					hits_q[g] <= '0;
				end else if (busy_q && sampleStrobe && over[g] && hits_q[g] != 3'h7) begin
					hits_q[g] <= hits_q[g] + 1'b1;
				end
			end
		end
	endgenerate

	// Every enabled channel, or any one of them
	logic anyMet;
	logic allMet;
	assign anyMet = |(met & chanEnable);
	assign allMet = ((met | ~chanEnable) == '1) && (chanEnable != '0);
	assign detect = busy_q && (cfg.requireEvery ? allMet : anyMet);
	assign done   = busy_q && (detect || (sampleCnt_q >= windowLen));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sampleCnt_q <= '0;
			busy_q      <= 1'b0;
		end else if (start) begin
			sampleCnt_q <= '0;
			busy_q      <= 1'b1;
		end else if (done) begin
			busy_q      <= 1'b0;
		end else if (busy_q && sampleStrobe) begin
			sampleCnt_q <= sampleCnt_q + 1'b1;
		end
	end

endmodule : stdp_tamper_window
`default_nettype wire

// ### hw/stdp_serial_mode.sv
// Purpose: Mode control and slave serial port for a two-channel converter
// Assumes: Serial clock, select, data and sync pins are asynchronous to clk
// Notes:   Conversion data and responses arrive on txWord* ports
// How it works
// - Two-bit field picks three power levels
// - Standby disables channels, keeps registers
// - Command 0022h enters standby
// - Command 0033h leaves standby
// - Sampling starts eight modulator periods later
// - Tamper samples at 2.7 kSPS against threshold
// - Enough hits: data-ready falls, back to standby
// - Short sync pulse in standby starts tamper
// - Tamper entered only from standby
// - Internal oscillator; results never shown
// - Enable bit permits tamper detection
// - Threshold is 24 bits, two halves
// - Window length field, 128 to 3584
// - Hit-count field rejects noisy samples
// - All-channels bit: every or any channel
// - Only enabled channels take part
// - Slave, SPI mode 1, full duplex
// - Select high: ignore, output released
// - Select high resets serial logic
// - Capture on falling, shift on rising
// - Data-ready is active low
`timescale 1ns/1ns
`default_nettype none
module stdp_serial_mode
	import stdp_pkg::*;
#(
	parameter int WIDTH = WORD_BITS
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             sclk,
	input  wire logic             csPin_b,
	input  wire logic             din,
	output logic                  dout,
	output logic                  doutOe,
	input  wire logic             syncPin_b,
	output logic                  dataReady_b,
	input  wire logic             modClkTick,
	input  wire logic             convDone,
	input  wire logic [1:0]       powerLevelSelect,
	input  wire logic [CHANNELS-1:0] channelEnable,
	input  wire logic             tamperDetectEnable,
	input  wire logic             tamperRequireEvery,
	input  wire logic [2:0]       tamperWindowLength,
	input  wire logic [2:0]       tamperHitCount,
	input  wire logic [11:0]      thresholdUpper,
	input  wire logic [11:0]      thresholdLower,
	input  wire stdp_samples_t    tamperSamples,
	input  wire logic             txWordValid,
	output logic                  txWordReady,
	input  wire logic [WIDTH-1:0] txWord,
	output logic                  rxWordValid,
	output logic      [WIDTH-1:0] rxWord,
	output logic      [1:0]       powerLevelActive,
	output logic      [CHANNELS-1:0] channelsActive,
	output logic                  referencePowered,
	output logic                  modulatorsSampling,
	output logic                  internalOscOn,
	output logic                  standbyState,
	output logic                  tamperState
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] sclkSync_q, csSync_q, dinSync_q, syncSync_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkSync_q <= '0;
			csSync_q   <= 2'h3;
			dinSync_q  <= '0;
			syncSync_q <= 2'h3;
		end else begin
			sclkSync_q <= {sclkSync_q[0], sclk};
			csSync_q   <= {csSync_q[0], csPin_b};
			dinSync_q  <= {dinSync_q[0], din};
			syncSync_q <= {syncSync_q[0], syncPin_b};
		end
	end

	logic sclkLast_q, syncLast_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclkLast_q <= 1'b0;
			syncLast_q <= 1'b1;
		end else begin
			sclkLast_q <= sclkSync_q[1];
			syncLast_q <= syncSync_q[1];
		end
	end

	logic selected, sclkRise, sclkFall;
	assign selected = !csSync_q[1];
	assign sclkRise = selected && sclkSync_q[1] && !sclkLast_q;
	assign sclkFall = selected && !sclkSync_q[1] && sclkLast_q;

	// ****************************************
	// Serial receive
	// ****************************************
	logic [WIDTH-1:0] rxShift_q;
	logic [4:0]       rxCnt_q;
	logic             rxDone;
	assign rxDone = sclkFall && (rxCnt_q == 5'(WIDTH-1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxShift_q <= '0;
			rxCnt_q   <= '0;
		end else if (!selected) begin
			rxCnt_q   <= '0;
		end else if (sclkFall) begin
			rxShift_q <= {rxShift_q[WIDTH-2:0], dinSync_q[1]};
			rxCnt_q   <= rxDone ? '0 : rxCnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxWordValid <= 1'b0;
			rxWord      <= '0;
		end else begin
			rxWordValid <= rxDone;
			if (rxDone) begin
				rxWord <= {rxShift_q[WIDTH-2:0], dinSync_q[1]};
			end
		end
	end

	logic cmdStandby, cmdWakeup;
	assign cmdStandby = rxWordValid && (rxWord == CMD_STANDBY);
	assign cmdWakeup  = rxWordValid && (rxWord == CMD_WAKEUP);

	// ****************************************
	// Serial transmit through two-entry buffer
	// ****************************************
	logic             bufValid, bufPop;
	logic [WIDTH-1:0] bufData;
	logic [WIDTH-1:0] txShift_q;
	logic [4:0]       txCnt_q;
	logic             txLoaded_q;
	logic             txBit_q;

	stdp_word_buffer #(.WIDTH(WIDTH), .DEPTH(2)) uBuf (
		.clk     (clk),
		.rst_b   (rst_b),
		.inValid (txWordValid),
		.inReady (txWordReady),
		.inData  (txWord),
		.outValid(bufValid),
		.outReady(bufPop),
		.outData (bufData)
	);

	assign bufPop = selected && !txLoaded_q && bufValid;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txShift_q  <= '0;
			txCnt_q    <= '0;
			txLoaded_q <= 1'b0;
			txBit_q    <= 1'b0;
		end else if (!selected) begin
			txCnt_q    <= '0;
			txLoaded_q <= 1'b0;
			txBit_q    <= 1'b0;
		end else if (bufPop) begin
			txShift_q  <= bufData;
			txLoaded_q <= 1'b1;
		end else if (sclkRise) begin
			txBit_q   <= txShift_q[WIDTH-1];
			txShift_q <= {txShift_q[WIDTH-2:0], 1'b0};
			if (txCnt_q == 5'(WIDTH-1)) begin
				txCnt_q    <= '0;
				txLoaded_q <= 1'b0;
			end else begin
				txCnt_q <= txCnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout   <= 1'b0;
			doutOe <= 1'b0;
		end else begin
			doutOe <= selected;
			dout   <= selected ? txBit_q : 1'b0;
		end
	end

	// ****************************************
	// Sync pulse width
	// ****************************************
	logic [7:0] syncLow_q;
	logic       shortPulse;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			syncLow_q <= '0;
		end else if (!syncSync_q[1]) begin
			syncLow_q <= (syncLow_q == 8'hFF) ? syncLow_q : syncLow_q + 1'b1;
		end else begin
			syncLow_q <= '0;
		end
	end
	assign shortPulse = syncSync_q[1] && !syncLast_q &&
		(syncLow_q < 8'(RESET_RECOG_CYC));

	// ****************************************
	// Internal oscillator tick
	// ****************************************
	logic [11:0] oscCnt_q;
	logic        oscTick;
	assign oscTick = (oscCnt_q == 12'(TAMPER_SAMPLE_CYC - 1));
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oscCnt_q <= '0;
		end else if (!internalOscOn || oscTick) begin
			oscCnt_q <= '0;
		end else begin
			oscCnt_q <= oscCnt_q + 1'b1;
		end
	end

	// ****************************************
	// Tamper window
	// ****************************************
	stdp_tamper_cfg_t cfg;
	logic             runStart, winDetect, winDone;
	assign cfg.enable       = tamperDetectEnable;
	assign cfg.requireEvery = tamperRequireEvery;
	assign cfg.windowLength = tamperWindowLength;
	assign cfg.hitCount     = tamperHitCount;
	assign cfg.threshold    = {thresholdUpper, thresholdLower};

	stdp_tamper_window #(.CH(CHANNELS)) uWin (
		.clk         (clk),
		.rst_b       (rst_b),
		.start       (runStart),
		.sampleStrobe(oscTick),
		.samples     (tamperSamples),
		.cfg         (cfg),
		.chanEnable  (channelEnable),
		.detect      (winDetect),
		.done        (winDone)
	);

	// ****************************************
	// Mode machine
	// ****************************************
	stdp_mode_t mode_q;
	logic [3:0] settle_q;
	assign runStart = (mode_q == MODE_STANDBY) && shortPulse && tamperDetectEnable;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q   <= MODE_RUN;
			settle_q <= '0;
		end else begin
			unique case (mode_q)
				MODE_RUN: begin
					if (cmdStandby) begin
						mode_q <= MODE_STANDBY;
					end
				end
				MODE_STANDBY: begin
					if (cmdWakeup) begin
						mode_q   <= MODE_SETTLE;
						settle_q <= '0;
					end else if (runStart) begin
						mode_q <= MODE_TAMPER;
					end
				end
				MODE_TAMPER: begin
					if (winDone) begin
						mode_q <= MODE_STANDBY;
					end
				end
				MODE_SETTLE: begin
					if (cmdStandby) begin
						mode_q <= MODE_STANDBY;
					end else if (modClkTick) begin
						if (settle_q == 4'(MOD_SETTLE_PERIODS - 1)) begin
							mode_q <= MODE_RUN;
						end
						settle_q <= settle_q + 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Data-ready and status
	// ****************************************
	logic detectPulse;
	assign detectPulse = (mode_q == MODE_TAMPER) && winDone && winDetect;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataReady_b <= 1'b1;
		end else if (detectPulse) begin
			dataReady_b <= 1'b0;
		end else if (mode_q == MODE_RUN && convDone) begin
			dataReady_b <= 1'b0;
		end else if (rxDone || cmdWakeup || runStart) begin
			dataReady_b <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			powerLevelActive   <= '0;
			channelsActive     <= '0;
			referencePowered   <= 1'b0;
			modulatorsSampling <= 1'b0;
			internalOscOn      <= 1'b0;
			standbyState       <= 1'b0;
			tamperState        <= 1'b0;
		end else begin
			powerLevelActive   <= powerLevelSelect;
			channelsActive     <= (mode_q == MODE_RUN) ? channelEnable : '0;
			referencePowered   <= (mode_q == MODE_RUN) || (mode_q == MODE_SETTLE);
			modulatorsSampling <= (mode_q == MODE_RUN);
			internalOscOn      <= (mode_q == MODE_TAMPER) || runStart;
			standbyState       <= (mode_q == MODE_STANDBY);
			tamperState        <= (mode_q == MODE_TAMPER);
		end
	end

endmodule : stdp_serial_mode
`default_nettype wire

// ### tb/stdp_serial_mode_sva.sv
// Purpose: Port-level assertions for the serial mode block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module stdp_serial_mode_chk
	import stdp_pkg::*;
#(
	parameter int WIDTH = WORD_BITS
) (
	input wire logic                clk,
	input wire logic                rst_b,
	input wire logic                csPin_b,
	input wire logic                doutOe,
	input wire logic                dataReady_b,
	input wire logic                tamperDetectEnable,
	input wire logic [1:0]          powerLevelSelect,
	input wire logic [1:0]          powerLevelActive,
	input wire logic [CHANNELS-1:0] channelsActive,
	input wire logic                referencePowered,
	input wire logic                internalOscOn,
	input wire logic                standbyState,
	input wire logic                tamperState,
	input wire logic                rxWordValid,
	input wire logic [WIDTH-1:0]    rxWord
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_oe_idle; csPin_b [*4] |-> !doutOe; endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("output enabled while deselected");
	property p_rx_pulse; rxWordValid |=> !rxWordValid; endproperty
	a_rx_pulse: assert property (p_rx_pulse)
		else $error("received word strobe longer than one cycle");
	property p_rx_hold; !rxWordValid |=> rxWordValid || $stable(rxWord); endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("received word changed without a strobe");
	property p_standby_cmd; rxWordValid && rxWord == CMD_STANDBY && !tamperState |-> ##2 standbyState; endproperty
	a_standby_cmd: assert property (p_standby_cmd)
		else $error("standby command not obeyed");
	property p_standby_off; standbyState [*2] |-> channelsActive == '0 && !referencePowered; endproperty
	a_standby_off: assert property (p_standby_off)
		else $error("circuits powered in standby");
	property p_tamper_entry;
		$rose(tamperState) |-> $past(standbyState) && $past(tamperDetectEnable);
	endproperty
	a_tamper_entry: assert property (p_tamper_entry)
		else $error("tamper mode entered illegally");
	property p_tamper_osc; tamperState [*2] |-> internalOscOn; endproperty
	a_tamper_osc: assert property (p_tamper_osc)
		else $error("internal oscillator off in tamper mode");
	property p_tamper_exit; $fell(tamperState) |-> standbyState; endproperty
	a_tamper_exit: assert property (p_tamper_exit)
		else $error("tamper run did not return to standby");
	property p_power; $stable(powerLevelSelect) [*3] |-> powerLevelActive == powerLevelSelect; endproperty
	a_power: assert property (p_power)
		else $error("power level not applied");
	property p_data_ready_n_release; rxWordValid |-> ##[1:2] dataReady_b; endproperty
	a_data_ready_n_release: assert property (p_data_ready_n_release)
		else $error("data ready not released after a word");

	c_rx: cover property (rxWordValid && rxWord == CMD_STANDBY);
	c_tamper: cover property ($rose(tamperState));
	c_detect: cover property ($fell(dataReady_b) && standbyState);
endmodule : stdp_serial_mode_chk

bind stdp_serial_mode stdp_serial_mode_chk #(.WIDTH(WIDTH)) u_chk (
	.clk(clk), .rst_b(rst_b), .csPin_b(csPin_b), .doutOe(doutOe), .dataReady_b(dataReady_b),
	.tamperDetectEnable(tamperDetectEnable), .powerLevelSelect(powerLevelSelect),
	.powerLevelActive(powerLevelActive), .channelsActive(channelsActive),
	.referencePowered(referencePowered), .internalOscOn(internalOscOn), .standbyState(standbyState),
	.tamperState(tamperState), .rxWordValid(rxWordValid), .rxWord(rxWord)
);
`default_nettype wire

// ### tb/stdp_host_model.sv
// Purpose: Host model, SPI mode 1 master for the serial port
// Assumes: Driven off falling clk edges, 800 ns serial clock
// Notes:   Data line shows the inverse of its last bit when idle
`timescale 1ns/1ns
`default_nettype none
module stdp_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      csPin_b,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b0;
		csPin_b = 1'b1;
		din = 1'b0;
	end

	// ****************************************
	// One frame, cut short after nBits
	// ****************************************
	task automatic frame(input logic [15:0] txd, input int nBits, output logic [15:0] rxd);
		rxd = 16'h0000;
		@(negedge clk);
		csPin_b = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 15; i > 15 - nBits; i--) begin
			sclk = 1'b1;
			din = txd[i];
			repeat (4) @(negedge clk);
			sclk = 1'b0;
			rxd[i] = dout;
			repeat (4) @(negedge clk);
		end
		repeat (4) @(negedge clk);
		csPin_b = 1'b1;
		din = ~din;
	endtask : frame
endmodule : stdp_host_model
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for the serial mode block
// Assumes: Inputs change on falling clk edges
// Notes:   Tamper run ends early on detect to keep the run short
`timescale 1ns/1ns
`default_nettype none
module testbench
	import stdp_pkg::*;
;
	logic          clk, rst_b, syncPin_b, modClkTick, convDone, txWordValid;
	logic          tamperDetectEnable, tamperRequireEvery;
	logic [1:0]    powerLevelSelect, channelEnable;
	logic [2:0]    tamperWindowLength, tamperHitCount;
	logic [11:0]   thresholdUpper, thresholdLower;
	logic [15:0]   txWord, rxd;
	stdp_samples_t tamperSamples;
	wire logic     sclk, csPin_b, din, dout, doutOe, dataReady_b, txWordReady, rxWordValid;
	wire logic     referencePowered, modulatorsSampling, internalOscOn, standbyState, tamperState;
	wire logic [15:0] rxWord;
	wire logic [1:0]  powerLevelActive, channelsActive;
	int            checks = 0;
	int            miscompares = 0;

	stdp_host_model u_host (.clk(clk), .sclk(sclk), .csPin_b(csPin_b), .din(din), .dout(dout));
	stdp_serial_mode u_dut (
		.clk(clk), .rst_b(rst_b), .sclk(sclk), .csPin_b(csPin_b), .din(din), .dout(dout),
		.doutOe(doutOe), .syncPin_b(syncPin_b), .dataReady_b(dataReady_b), .modClkTick(modClkTick),
		.convDone(convDone), .powerLevelSelect(powerLevelSelect), .channelEnable(channelEnable),
		.tamperDetectEnable(tamperDetectEnable), .tamperRequireEvery(tamperRequireEvery),
		.tamperWindowLength(tamperWindowLength), .tamperHitCount(tamperHitCount),
		.thresholdUpper(thresholdUpper), .thresholdLower(thresholdLower), .tamperSamples(tamperSamples),
		.txWordValid(txWordValid), .txWordReady(txWordReady), .txWord(txWord),
		.rxWordValid(rxWordValid), .rxWord(rxWord), .powerLevelActive(powerLevelActive),
		.channelsActive(channelsActive), .referencePowered(referencePowered),
		.modulatorsSampling(modulatorsSampling), .internalOscOn(internalOscOn),
		.standbyState(standbyState), .tamperState(tamperState)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask : cycles
	task automatic syncPulse();
		@(negedge clk);
		syncPin_b = 1'b0;
		cycles(5);
		syncPin_b = 1'b1;
		cycles(10);
	endtask : syncPulse
	task automatic push(input logic [15:0] w, input logic expReady);
		@(negedge clk);
		txWord = w;
		txWordValid = 1'b1;
		#1;
		check("txWordReady", {31'h0, txWordReady}, {31'h0, expReady});
		@(negedge clk);
		txWordValid = 1'b0;
	endtask : push
	// Ticks only outside standby and tamper
	task automatic tick();
		@(negedge clk);
		modClkTick = 1'b1;
		@(negedge clk);
		modClkTick = 1'b0;
		cycles(2);
	endtask : tick

	initial begin
		#5_000_000;
		miscompares++;
		end_sim();
	end

	initial begin
		rst_b = 1'b0;
		syncPin_b = 1'b1;
		modClkTick = 1'b0;
		convDone = 1'b0;
		txWordValid = 1'b0;
		txWord = 16'h0000;
		powerLevelSelect = 2'h2;
		channelEnable = 2'h3;
		tamperDetectEnable = 1'b1;
		tamperRequireEvery = 1'b1;
		tamperWindowLength = 3'h0;
		tamperHitCount = 3'h2;
		thresholdUpper = 12'h001;
		thresholdLower = 12'h100;
		tamperSamples = '{valid: 2'h3, sample0: 24'hFF_E000, sample1: 24'h00_0010};
		cycles(6);
		rst_b = 1'b1;
		cycles(3);
		check("dataReady_b", dataReady_b, 1);
		check("doutOe", doutOe, 0);
		for (int p = 0; p < 4; p++) begin
			powerLevelSelect = p[1:0];
			cycles(4);
			check("powerLevelActive", powerLevelActive, p);
		end
		convDone = 1'b1;
		cycles(1);
		convDone = 1'b0;
		cycles(3);
		check("dataReady_b", dataReady_b, 0);
		push(16'hA5C3, 1'b1);
		push(16'h5A3C, 1'b1);
		push(16'h0F0F, 1'b0);
		u_host.frame(16'h1234, 16, rxd);
		check("dout word", rxd, 16'hA5C3);
		check("rxWord", rxWord, 16'h1234);
		check("dataReady_b", dataReady_b, 1);
		cycles(4);
		check("doutOe", doutOe, 0);
		syncPulse();
		check("tamperState", tamperState, 0);
		u_host.frame(16'hFFFF, 5, rxd);
		u_host.frame(CMD_STANDBY, 16, rxd);
		cycles(4);
		check("rxWord", rxWord, 16'h0022);
		check("standbyState", standbyState, 1);
		check("channelsActive", channelsActive, 0);
		check("referencePowered", referencePowered, 0);
		check("powerLevelActive", powerLevelActive, 3);
		check("txWordReady", txWordReady, 1);
		tamperDetectEnable = 1'b0;
		syncPulse();
		check("tamperState", tamperState, 0);
		tamperDetectEnable = 1'b1;
		channelEnable = 2'h1;
		syncPulse();
		check("tamperState", tamperState, 1);
		check("internalOscOn", internalOscOn, 1);
		for (int k = 0; k < 20000 && dataReady_b !== 1'b0; k++) begin
			@(negedge clk);
		end
		check("dataReady_b", dataReady_b, 0);
		cycles(3);
		check("standbyState", standbyState, 1);
		check("tamperState", tamperState, 0);
		channelEnable = 2'h3;
		u_host.frame(CMD_WAKEUP, 16, rxd);
		cycles(4);
		check("dataReady_b", dataReady_b, 1);
		check("standbyState", standbyState, 0);
		for (int t = 0; t < 7; t++) begin
			tick();
			check("modulatorsSampling", modulatorsSampling, 0);
		end
		tick();
		cycles(3);
		check("modulatorsSampling", modulatorsSampling, 1);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
